// ==== common/stall_pkg.sv ====
// Purpose: shared constants and carriers for the pipeline stall controller
// Assumes: one pipeline cycle per clock edge, big-endian bit numbering for bundles
// Notes: every figure used by more than one file lives here
package stall_pkg;

    // ****************************************
    // timing and field constants
    // ****************************************
    localparam int unsigned CLOCK_MHZ = 20;
    localparam int unsigned ITLB_PENALTY = 11;
    localparam int unsigned ILB_LONG = 2;
    localparam int unsigned ILB_SHORT = 1;
    localparam int unsigned RET_HALF = 2;
    localparam int unsigned TLB_OP_CYCLES = 3;
    localparam int unsigned CNT_W = 4;
    localparam int unsigned REG_W = 5;
    localparam int unsigned FIELD_A_LO = 21;
    localparam int unsigned FIELD_B_LO = 16;
    localparam logic [4:0] CR_NO_LOCK = 5'h0b;
    localparam logic [4:0] CR_LOAD_A = 5'h11;
    localparam logic [4:0] CR_LOAD_B = 5'h13;
    localparam logic [4:0] CR_LOAD_C = 5'h14;
    localparam logic [5:0] SLOT_OPC_MASK = 6'h3a;
    localparam logic [5:0] SLOT_OPC_VAL = 6'h00;
    localparam logic [31:0] SEQ_OFFSET = 32'h0000_0008;

    typedef enum logic [2:0] {
        BR_NONE, BR_REL_FWD, BR_REL_BACK, BR_GATE,
        BR_LINK_REG, BR_VECTORED, BR_EXTERNAL, BR_EXT_LINK
    } branch_kind_t;

    typedef enum logic [1:0] {MT_NONE, MT_CTL, MT_SPACE, MT_CPU} move_to_t;

    typedef enum logic [1:0] {LD_NONE, LD_MEM, LD_CTL, LD_OTHER} load_kind_t;

    typedef struct packed {
        branch_kind_t kind;
        logic in_delay_slot;
        logic [5:0] slot_owner_opc;
        logic ireturn_target;
        logic nullified;
    } branch_info_t;

    typedef struct packed {
        logic dcache_miss;
        logic flush;
        logic mispredict;
        logic branch_taken;
        logic ireturn;
        logic trapped;
        logic nullified;
        logic sq_write;
        logic rmw_read;
        logic subword_store;
        logic next_memref;
        logic tlb_op;
        load_kind_t load_kind;
        logic [4:0] load_cr;
        logic load_miss;
        logic [4:0] load_target;
        logic [31:0] next_bundle;
        move_to_t move_to;
        logic [4:0] move_cr;
        logic ilb_miss;
        logic branch_new_page;
        logic branch_memref;
        logic utb_miss;
        logic pgdir_hit;
        logic icache_miss;
    } stall_req_t;

    typedef struct packed {
        logic stall;
        logic second_phase_en;
        logic fetch_continue;
        logic status_restore;
        logic squash_next;
        logic sr0_write;
        logic ilb_update;
        logic interlock_step;
        logic sys_reg_write;
        logic miss_handle;
        logic tlb_op_go;
        logic pgdir_fetch;
        logic utb_insert;
        logic late_rmw_read;
        logic predict_valid;
        logic predict_taken;
    } stall_ctl_t;

endpackage : stall_pkg

// ==== design/branch_predict.sv ====
// Purpose: static branch prediction for the fetched branch
// Assumes: branch_info valid in the same cycle it is read
// Notes: purely combinational, the caller registers the result
`timescale 1ns/1ns
`default_nettype none
module branch_predict (
    input wire stall_pkg::branch_info_t br,
    output logic pred_valid,
    output logic pred_taken
);
    logic slot_block;

    always_comb
    begin
        slot_block = br.in_delay_slot &&
            ((br.slot_owner_opc & stall_pkg::SLOT_OPC_MASK) == stall_pkg::SLOT_OPC_VAL);
        pred_valid = 1'b0;
        pred_taken = 1'b0;
        // nullified is deliberately not consulted
        case (br.kind)
            stall_pkg::BR_REL_FWD:
            begin
                pred_valid = 1'b1;
                pred_taken = 1'b0;
            end
            stall_pkg::BR_REL_BACK:
            begin
                pred_valid = 1'b1;
                pred_taken = !(slot_block || br.ireturn_target);
            end
            default:
            begin
                pred_valid = 1'b0;
                pred_taken = 1'b0;
            end
        endcase
    end
endmodule : branch_predict
`default_nettype wire

// ==== design/use_scoreboard.sv ====
// Purpose: records the target of a load that retired early on a cache miss
// Assumes: one outstanding early-retired load at a time
// Notes: a new record in the cycle the data lands wins over the clear
`timescale 1ns/1ns
`default_nettype none
module use_scoreboard (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic record,
    input wire logic [4:0] target,
    input wire logic data_arrived,
    input wire logic [31:0] bundle,
    output logic hit
);
    logic pending_q;
    logic [4:0] target_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pending_q <= 1'b0;
            target_q <= 5'h00;
        end
        else if (ce)
        begin
            if (record)
            begin
                pending_q <= 1'b1;
                target_q <= target;
            end
            else if (data_arrived)
            begin
                pending_q <= 1'b0;
            end
        end
    end

    assign hit = pending_q && !data_arrived &&
        (bundle[stall_pkg::FIELD_A_LO +: stall_pkg::REG_W] == target_q ||
         bundle[stall_pkg::FIELD_B_LO +: stall_pkg::REG_W] == target_q);
endmodule : use_scoreboard
`default_nettype wire

// ==== design/pipeline_stall_control.sv ====
// Purpose: pipeline hang sequencing for a superscalar core
// Assumes: decode holds its request stable while stall is high
// Notes: one clock edge is one hang state, second phase is gated by stall
`timescale 1ns/1ns
`default_nettype none
// Contract
// - freeze only between first and second phase; advance spans second to first
// - several pending stalls: highest fixed priority serviced next
// - data cache miss of load, store or load-and-clear stalls after result first phase
// - data cache flush, flush-entry, purge always stall at least one cycle
// - misprediction costs one cycle; external, vectored, return cost one more
// - register-dependent branches are never predicted
// - forward relative conditional branches predicted not taken
// - backward relative predicted taken unless in marked delay slot or return target
// - nullify indication does not affect prediction
// - interruption return stalls twice, two cycles each
// - keep fetching one cycle from target or queue head plus 8
// - first return hang state restores status word unless trapped; squash follower
// - store queue write beats read-modify-write read; read waits one cycle
// - subword store without memory follower does not stall; reads late
// - translation insert, purge, diagnose stall multi-state unless trapped or nullified
// - load-use on bundle fields 6:10 or 11:15 matching load target
// - loads include control reads 17, 19, 20 and other register reads
// - moves to control (not 11), space, cpu registers always interlock
// - cpu interlock at most once per instruction with an interlock step
// - interlock step writes system registers and handles load misses
// - missed load retires early; later read of target stalls until data
// - lookaside buffer miss stalls two cycles, one for lone new-page branch
// - hardware translation miss fetches directory, inserts; 11 cycles on hit
// - instruction cache miss stalls until critical data, then streams
module pipeline_stall_control (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire stall_pkg::stall_req_t req,
    input wire stall_pkg::branch_info_t br,
    input wire logic [31:0] branch_target,
    input wire logic [31:0] queue_head,
    input wire logic critical_data_valid,
    input wire logic [31:0] addr_in,
    input wire logic [63:0] operand_in,
    output stall_pkg::stall_ctl_t ctl_q,
    output logic [31:0] fetch_addr_q,
    output logic [31:0] addr_q,
    output logic [63:0] operand_q
);
    typedef enum logic [3:0] {
        S_RUN, S_DCACHE, S_MISPRED, S_IRETURN, S_STORE, S_TLBOP,
        S_LOCK, S_USE, S_ILB, S_ITLB, S_ICACHE
    } hang_t;

    hang_t state_q;
    logic [stall_pkg::CNT_W-1:0] cnt_q;
    logic ret_second_q;
    logic locked_q;
    logic pred_valid;
    logic pred_taken;
    logic use_hit;
    logic is_load;
    logic move_lock;
    logic load_use;
    logic lock_need;
    logic store_col;
    logic tlb_need;
    logic dc_need;
    logic extra_cycle;

    // ****************************************
    // condition decode
    // ****************************************
    branch_predict u_pred (
        .br(br),
        .pred_valid(pred_valid),
        .pred_taken(pred_taken)
    );

    use_scoreboard u_sou (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .record(state_q == S_RUN && !ctl_q.stall && req.load_miss &&
            req.load_kind != stall_pkg::LD_NONE),
        .target(req.load_target),
        .data_arrived(critical_data_valid),
        .bundle(req.next_bundle),
        .hit(use_hit)
    );

    always_comb
    begin
        is_load = req.load_kind == stall_pkg::LD_MEM || req.load_kind == stall_pkg::LD_OTHER ||
            (req.load_kind == stall_pkg::LD_CTL && (req.load_cr == stall_pkg::CR_LOAD_A ||
            req.load_cr == stall_pkg::CR_LOAD_B || req.load_cr == stall_pkg::CR_LOAD_C));
        load_use = is_load &&
            (req.next_bundle[stall_pkg::FIELD_A_LO +: stall_pkg::REG_W] == req.load_target ||
             req.next_bundle[stall_pkg::FIELD_B_LO +: stall_pkg::REG_W] == req.load_target);
        move_lock = (req.move_to == stall_pkg::MT_CTL && req.move_cr != stall_pkg::CR_NO_LOCK) ||
            req.move_to == stall_pkg::MT_SPACE || req.move_to == stall_pkg::MT_CPU;
        lock_need = (load_use || move_lock) && !locked_q;
        // subword store with no memory follower skips the collision stall
        store_col = req.sq_write && req.rmw_read &&
            !(req.subword_store && !req.next_memref);
        tlb_need = req.tlb_op && !req.trapped && !req.nullified;
        dc_need = req.dcache_miss || req.flush;
        extra_cycle = br.kind == stall_pkg::BR_EXTERNAL || br.kind == stall_pkg::BR_EXT_LINK ||
            br.kind == stall_pkg::BR_VECTORED;
    end

    // ****************************************
    // hang sequencer
    // ****************************************
    // the order of the if chain is the service priority
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q <= S_RUN;
            cnt_q <= '0;
            ret_second_q <= 1'b0;
        end
        else if (ce)
        begin
            case (state_q)
                S_RUN:
                begin
                    if (ctl_q.stall) // request still belongs to the hang just ended
                    begin
                        ret_second_q <= 1'b0;
                    end
                    else if (dc_need)
                    begin
                        state_q <= S_DCACHE;
                        cnt_q <= '0;
                    end
                    else if (req.ireturn)
                    begin
                        state_q <= S_IRETURN;
                        cnt_q <= stall_pkg::CNT_W'(stall_pkg::RET_HALF - 1);
                    end
                    else if (req.mispredict)
                    begin
                        state_q <= S_MISPRED;
                        cnt_q <= extra_cycle ? stall_pkg::CNT_W'(1) : '0;
                    end
                    else if (store_col)
                    begin
                        state_q <= S_STORE;
                        cnt_q <= '0;
                    end
                    else if (tlb_need)
                    begin
                        state_q <= S_TLBOP;
                        cnt_q <= stall_pkg::CNT_W'(stall_pkg::TLB_OP_CYCLES - 1);
                    end
                    else if (lock_need)
                    begin
                        state_q <= S_LOCK;
                        cnt_q <= '0;
                    end
                    else if (use_hit)
                    begin
                        state_q <= S_USE;
                    end
                    else if (req.ilb_miss && !req.utb_miss)
                    begin
                        state_q <= S_ILB;
                        cnt_q <= (req.branch_new_page && !req.branch_memref) ?
                            stall_pkg::CNT_W'(stall_pkg::ILB_SHORT - 1) :
                            stall_pkg::CNT_W'(stall_pkg::ILB_LONG - 1);
                    end
                    else if (req.ilb_miss && req.utb_miss)
                    begin
                        state_q <= S_ITLB;
                        cnt_q <= stall_pkg::CNT_W'(stall_pkg::ITLB_PENALTY - 1);
                    end
                    else if (req.icache_miss)
                    begin
                        state_q <= S_ICACHE;
                    end
                end
                S_DCACHE:
                begin
                    // a flush that hits still spends this one cycle
                    if (!req.dcache_miss || critical_data_valid)
                    begin
                        state_q <= S_RUN;
                    end
                end
                S_USE, S_ICACHE:
                begin
                    if (critical_data_valid)
                    begin
                        state_q <= S_RUN;
                    end
                end
                S_IRETURN:
                begin
                    if (cnt_q != '0)
                    begin
                        cnt_q <= cnt_q - stall_pkg::CNT_W'(1);
                    end
                    else if (!ret_second_q)
                    begin
                        ret_second_q <= 1'b1;
                        cnt_q <= stall_pkg::CNT_W'(stall_pkg::RET_HALF - 1);
                    end
                    else
                    begin
                        state_q <= S_RUN;
                    end
                end
                S_MISPRED, S_STORE, S_TLBOP, S_LOCK, S_ILB, S_ITLB:
                begin
                    if (cnt_q != '0)
                    begin
                        cnt_q <= cnt_q - stall_pkg::CNT_W'(1);
                    end
                    else
                    begin
                        state_q <= S_RUN;
                    end
                end
                default:
                begin
                    state_q <= S_RUN;
                end
            endcase
        end
    end

    // one interlock per instruction: cleared once the pipe really advances
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            locked_q <= 1'b0;
        end
        else if (ce)
        begin
            if (state_q == S_LOCK)
            begin
                locked_q <= 1'b1;
            end
            else if (state_q == S_RUN && !ctl_q.stall)
            begin
                locked_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // control outputs
    // ****************************************
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ctl_q <= '0;
            fetch_addr_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ctl_q.stall <= state_q != S_RUN;
            // freeze happens only by withholding the second phase
            ctl_q.second_phase_en <= state_q == S_RUN;
            ctl_q.fetch_continue <= state_q == S_MISPRED && cnt_q == '0;
            if (state_q == S_MISPRED && cnt_q == '0)
            begin
                fetch_addr_q <= req.branch_taken ? branch_target :
                    32'(queue_head + stall_pkg::SEQ_OFFSET);
            end
            ctl_q.status_restore <= state_q == S_IRETURN && !ret_second_q &&
                cnt_q == stall_pkg::CNT_W'(stall_pkg::RET_HALF - 1) && !req.trapped;
            ctl_q.squash_next <= state_q == S_IRETURN && !ret_second_q &&
                cnt_q == stall_pkg::CNT_W'(stall_pkg::RET_HALF - 1);
            ctl_q.sr0_write <= state_q == S_MISPRED && br.kind == stall_pkg::BR_EXT_LINK;
            ctl_q.ilb_update <= (state_q == S_MISPRED && (br.kind == stall_pkg::BR_EXTERNAL ||
                br.kind == stall_pkg::BR_EXT_LINK)) || (state_q == S_IRETURN && cnt_q == '0) ||
                (state_q == S_ILB && cnt_q == '0);
            ctl_q.interlock_step <= state_q == S_LOCK;
            ctl_q.sys_reg_write <= state_q == S_LOCK && move_lock;
            ctl_q.miss_handle <= state_q == S_LOCK && req.load_miss;
            ctl_q.tlb_op_go <= state_q == S_TLBOP &&
                cnt_q == stall_pkg::CNT_W'(stall_pkg::TLB_OP_CYCLES - 1);
            ctl_q.pgdir_fetch <= state_q == S_ITLB &&
                cnt_q == stall_pkg::CNT_W'(stall_pkg::ITLB_PENALTY - 1);
            ctl_q.utb_insert <= state_q == S_ITLB && cnt_q == '0 && req.pgdir_hit;
            ctl_q.late_rmw_read <= state_q == S_RUN && req.subword_store &&
                !req.next_memref;
            ctl_q.predict_valid <= pred_valid;
            ctl_q.predict_taken <= pred_taken;
        end
    end

    // operands from the last step are repeated through the freeze
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            addr_q <= 32'h0000_0000;
            operand_q <= 64'h0000_0000_0000_0000;
        end
        else if (ce && state_q == S_RUN)
        begin
            addr_q <= addr_in;
            operand_q <= operand_in;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_phase_gate: assert property (@(posedge clock) disable iff (rst)
        ctl_q.stall |-> !ctl_q.second_phase_en)
        else $error("second phase enabled during a freeze");
    a_flush_min: assert property (@(posedge clock) disable iff (rst)
        (ce && state_q == S_RUN && !ctl_q.stall && req.flush) |=> ##1 ctl_q.stall)
        else $error("flush did not stall");
    a_mispred_len: assert property (@(posedge clock) disable iff (rst)
        (ce && state_q == S_RUN && !ctl_q.stall && !dc_need && !req.ireturn &&
        req.mispredict && !extra_cycle) |=> state_q == S_MISPRED ##1 state_q == S_RUN)
        else $error("plain misprediction not one cycle");
    a_ret_len: assert property (@(posedge clock) disable iff (rst || !ce)
        $rose(state_q == S_IRETURN) |-> (state_q == S_IRETURN) [*4] ##1 state_q == S_RUN)
        else $error("return hang not four cycles");
    a_store_once: assert property (@(posedge clock) disable iff (rst || !ce)
        state_q == S_STORE |=> state_q == S_RUN)
        else $error("store collision held over one cycle");
    a_itlb_len: assert property (@(posedge clock) disable iff (rst || !ce)
        $rose(state_q == S_ITLB) |-> ##10 state_q == S_ITLB ##1
        (state_q == S_RUN && ctl_q.utb_insert == $past(req.pgdir_hit)))
        else $error("translation miss penalty wrong");
    a_lock_once: assert property (@(posedge clock) disable iff (rst || !ce)
        state_q == S_LOCK |=> state_q != S_LOCK)
        else $error("second interlock for one instruction");
    a_use_wait: assert property (@(posedge clock) disable iff (rst || !ce)
        (state_q == S_USE && !critical_data_valid) |=> state_q == S_USE)
        else $error("stall-on-use left before data");
    a_operand_hold: assert property (@(posedge clock) disable iff (rst || !ce)
        (state_q != S_RUN) |=> $stable(addr_q) && $stable(operand_q))
        else $error("operands moved during freeze");
    a_no_predict: assert property (@(posedge clock) disable iff (rst || !ce)
        (br.kind == stall_pkg::BR_VECTORED || br.kind == stall_pkg::BR_GATE) |=>
        !ctl_q.predict_valid)
        else $error("register branch predicted");
endmodule : pipeline_stall_control
`default_nettype wire

// ==== testbench/mem_ctrl_model.sv ====
// Purpose: memory controller stand-in that hands back critical data
// Assumes: a miss is outstanding only while the bench says so
// Notes: one-cycle data pulse, never a level
`timescale 1ns/1ns
`default_nettype none
module mem_ctrl_model #(
    parameter int DELAY = 5
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic miss,
    input wire logic stall,
    output logic data_valid
);
    logic [3:0] cnt_q;
    // counts on past the pulse and wraps at 16, so a hang sees a second delivery only 16 cycles after the first
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 4'h0;
            data_valid <= 1'b0;
        end
        else
        begin
            data_valid <= miss && stall && (cnt_q == 4'(DELAY - 1));
            cnt_q <= (miss && stall) ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule : mem_ctrl_model
`default_nettype wire

// ==== testbench/pipeline_stall_control_tb.sv ====
// Purpose: self-checking bench for the stall sequencer
// Assumes: ce held high, one request per hang except the priority case, which raises flush and tlb_op together
// Notes: hang lengths counted on falling edges
`timescale 1ns/1ns
`default_nettype none
module pipeline_stall_control_tb;
    localparam int DLY = 5;
    logic clock, rst, ce, dv;
    stall_pkg::stall_req_t req;
    stall_pkg::branch_info_t br;
    logic [31:0] tgt, head, addr_in, fa_q, addr_q, a1;
    logic [63:0] op_q;
    stall_pkg::stall_ctl_t ctl_q, c1;
    logic [31:0] f1;
    int errors = 0;
    int checked = 0;
    pipeline_stall_control u_dut (.clock(clock), .rst(rst), .ce(ce), .req(req), .br(br),
        .branch_target(tgt), .queue_head(head), .critical_data_valid(dv), .addr_in(addr_in),
        .operand_in(64'h0123_4567_89ab_cdef), .ctl_q(ctl_q), .fetch_addr_q(fa_q),
        .addr_q(addr_q), .operand_q(op_q));
    mem_ctrl_model #(.DELAY(DLY)) u_mem (.clock(clock), .rst(rst),
        .miss(req.dcache_miss | req.icache_miss | req.load_miss), .stall(ctl_q.stall),
        .data_valid(dv));
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(negedge clock) addr_in <= rst ? 32'h0000_0100 : addr_in + 32'h0000_0004;
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic compare_word(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : compare_word
    task automatic compare_len(input string name, input int lo, input int hi, input int g);
        checked++;
        if (g < lo || g > hi)
        begin
            errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, g);
        end
    endtask : compare_len
    // caller has set req at a falling edge; lo/hi bound the hang length
    task automatic run_stall(input string name, input int lo, input int hi);
        int n;
        int w;
        n = 0;
        w = 0;
        while (ctl_q.stall !== 1'b1 && w < 6)
        begin
            @(negedge clock);
            w++;
        end
        c1 = ctl_q;
        f1 = fa_q;
        a1 = addr_q;
        while (ctl_q.stall === 1'b1 && n < 40)
        begin
            if (n == 5)
                compare_word("held addr", a1, addr_q);
            n++;
            @(negedge clock);
        end
        compare_len(name, lo, hi, n);
        req = '0;
        w = 0;
        while (w < 3 && n < 80)
        begin
            @(negedge clock);
            w = (ctl_q.stall === 1'b0) ? w + 1 : 0;
            n++;
        end
        if (n >= 40)
        begin
            errors++;
            complete_run();
        end
        $display("case %s done", name);
    endtask : run_stall
    task automatic pred(input string name, input stall_pkg::branch_kind_t k, input logic slot,
        input logic [5:0] opc, input logic rt, input logic v, input logic t);
        br = '{kind: k, in_delay_slot: slot, slot_owner_opc: opc, ireturn_target: rt,
            nullified: t};
        @(negedge clock);
        compare_word({name, " valid"}, {31'h0, v}, {31'h0, ctl_q.predict_valid});
        compare_word({name, " taken"}, {31'h0, t}, {31'h0, ctl_q.predict_taken});
        $display("case %s done", name);
    endtask : pred
    task automatic t_predict();
        pred("back", stall_pkg::BR_REL_BACK, 1'b0, 6'h00, 1'b0, 1'b1, 1'b1);
        pred("slot", stall_pkg::BR_REL_BACK, 1'b1, 6'h05, 1'b0, 1'b1, 1'b0);
        pred("slot2", stall_pkg::BR_REL_BACK, 1'b1, 6'h08, 1'b0, 1'b1, 1'b1);
        pred("ret tgt", stall_pkg::BR_REL_BACK, 1'b0, 6'h00, 1'b1, 1'b1, 1'b0);
        pred("fwd", stall_pkg::BR_REL_FWD, 1'b0, 6'h00, 1'b0, 1'b1, 1'b0);
        for (int k = 3; k < 8; k++)
            pred("reg", stall_pkg::branch_kind_t'(k), 1'b0, 6'h00, 1'b0, 1'b0, 1'b0);
        br = '0;
    endtask : t_predict
    task automatic t_mispredict();
        req.mispredict = 1'b1;
        run_stall("mispredict", 1, 1);
        compare_word("continue", 32'h1, {31'h0, c1.fetch_continue});
        compare_word("seq fetch", head + stall_pkg::SEQ_OFFSET, f1);
        req.mispredict = 1'b1;
        req.branch_taken = 1'b1;
        br.kind = stall_pkg::BR_EXTERNAL;
        run_stall("external", 2, 2);
        compare_word("tgt fetch", tgt, fa_q);
        br = '0;
    endtask : t_mispredict
    task automatic t_ret();
        req.ireturn = 1'b1;
        run_stall("int return", 4, 4);
        compare_word("status", 32'h1, {31'h0, c1.status_restore});
        compare_word("squash", 32'h1, {31'h0, c1.squash_next});
        compare_word("operand", 32'h89ab_cdef, op_q[31:0]);
    endtask : t_ret
    task automatic t_misc();
        req.flush = 1'b1;
        run_stall("flush", 1, 1);
        req.flush = 1'b1;
        req.tlb_op = 1'b1;
        run_stall("priority", 1, 1);
        req.dcache_miss = 1'b1;
        run_stall("dmiss", DLY, DLY + 3);
        req.sq_write = 1'b1;
        req.rmw_read = 1'b1;
        run_stall("collide", 1, 1);
        req.sq_write = 1'b1;
        req.rmw_read = 1'b1;
        req.subword_store = 1'b1;
        run_stall("subword", 0, 0);
        compare_word("late read", 32'h1, {31'h0, c1.late_rmw_read});
        req.tlb_op = 1'b1;
        run_stall("tlb op", 3, 3);
        req.tlb_op = 1'b1;
        req.nullified = 1'b1;
        run_stall("tlb null", 0, 0);
    endtask : t_misc
    task automatic t_interlock();
        req.move_to = stall_pkg::MT_SPACE;
        run_stall("space move", 1, 1);
        compare_word("step", 32'h3, {30'h0, c1.interlock_step, c1.sys_reg_write});
        req.move_to = stall_pkg::MT_CTL;
        req.move_cr = stall_pkg::CR_NO_LOCK;
        run_stall("ctl 11 move", 0, 0);
        req.load_kind = stall_pkg::LD_MEM;
        req.load_target = 5'h07;
        req.next_bundle = 32'h0007_0000;
        run_stall("load use", 1, 1);
        req.load_kind = stall_pkg::LD_CTL;
        req.load_cr = stall_pkg::CR_LOAD_B;
        req.load_target = 5'h09;
        req.next_bundle = 32'h0120_0000;
        run_stall("ctl read", 1, 1);
        req.load_kind = stall_pkg::LD_MEM;
        req.load_miss = 1'b1;
        req.load_target = 5'h0c;
        run_stall("miss retire", 0, 0);
        req.load_miss = 1'b1;
        req.next_bundle = 32'h0180_0000;
        run_stall("use", DLY, DLY + 3);
    endtask : t_interlock
    task automatic t_fetch();
        req.ilb_miss = 1'b1;
        run_stall("lookaside", 2, 2);
        req.ilb_miss = 1'b1;
        req.branch_new_page = 1'b1;
        run_stall("lookaside page", 1, 1);
        req.ilb_miss = 1'b1;
        req.utb_miss = 1'b1;
        req.pgdir_hit = 1'b1;
        run_stall("itlb", 11, 11);
        req.icache_miss = 1'b1;
        run_stall("imiss", DLY, DLY + 3);
    endtask : t_fetch
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        br = '0;
        tgt = 32'h0000_4000;
        head = 32'h0000_1230;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        t_predict();
        t_mispredict();
        t_ret();
        t_misc();
        t_interlock();
        t_fetch();
        complete_run();
    end
endmodule : pipeline_stall_control_tb
`default_nettype wire
